//--- rtl/param_regs.v
`timescale 1ns/1ns
`include "param_regs_defines.vh"

// Function
// - Writes to input one, input two and control data tags get an error answer.
// - Analog writes 0001-0074 wait for the non-volatile cycle before answering.
// - Host setpoint override is never stored and only honoured in slave mode.
// - Digital writes 0080-00FA start the non-volatile commit on receipt.
// - Infrared accepts codes 20, 21; wired ports accept 1,2,3,4,6,16,17,20,21.
// - With shed timer enabled, a write or override outside emergency manual enters slave mode, locking keypad.
// - In slave mode, shed timer expiry enters the configured shed state.
// - Manual/auto key in slave mode enters emergency manual, operator owns output.
// - Shed timer disabled means monitor mode.
// - Option flags read as 0 to 255, one bit per option.
// - Local setpoint count accepts 00 or 01 only.
// - Local setpoints are read/write floats clamped to the setpoint limits.
// - Software kind and revision are read-only; revision always below 255.
// - Setpoint program status registers are read-only.
// - Floats are 32-bit words; integers sit in the low 16 bits.
module param_regs #(
  parameter MS_CYCLES = `NS_PER_MS * `TICK_TIME_MS / `CLK_PERIOD_NS, // Cycles per ms tick
  parameter SW_KIND   = 16'h0001,                                  // Arbitrary identity
  parameter SW_REV    = 8'h01                                      // Arbitrary revision
) (
  input  wire        CLOCK,           // 125 MHz clock
  input  wire        RST,             // Synchronous reset, high
  input  wire        REQ_VALID,       // Decoded request present
  input  wire        REQ_IR,          // Request came from infrared port
  input  wire [7:0]  REQ_FUNC,        // Function code
  input  wire [7:0]  REQ_TAG,         // Register tag
  input  wire [31:0] REQ_WDATA,       // Write data
  output reg         REQ_READY,       // Request may be taken
  output reg         RSP_VALID,       // Answer pulse
  output reg         RSP_ERROR,       // Answer is an exception
  output reg  [31:0] RSP_DATA,        // Read data
  output reg         NV_REQ,          // Non-volatile write pulse
  output reg  [7:0]  NV_TAG,          // Tag being committed
  output reg  [31:0] NV_DATA,         // Value being committed
  input  wire        NV_DONE,         // Non-volatile write finished
  input  wire [31:0] PROCESS_VALUE,   // Control data word
  input  wire [31:0] INPUT_ONE,       // Input one value
  input  wire [31:0] INPUT_TWO,       // Input two value
  input  wire [7:0]  OPTION_FLAGS,    // Installed options
  input  wire [15:0] PROG_SEGMENT,    // Program segment 1..12
  input  wire [15:0] PROG_MINUTES,    // Minutes left 0..59
  input  wire [15:0] PROG_HOURS,      // Hours left 0..99
  input  wire [15:0] PROG_CYC_LEFT,   // Cycles left 0..100
  input  wire [15:0] PROG_CYC_INDEX,  // Current cycle 0..100
  input  wire        SHED_ENABLE,     // Shed timer enabled
  input  wire [7:0]  SHED_SECONDS,    // Shed time, 0 holds forever
  input  wire [1:0]  SHED_MODE_CFG,   // Configured shed mode and output
  input  wire        SHED_RECALL_CFG, // Configured shed setpoint recall
  input  wire        MANUAL_AUTO_KEY, // Manual/auto key pin
  input  wire        SP_TWO_SELECT,   // Operator picks second setpoint
  output reg  [1:0]  COMM_MODE,       // Communication mode
  output reg         KEYPAD_LOCK,     // Keypad locked
  output reg         SHED_ACTIVE,     // Shed state entered
  output reg  [1:0]  SHED_MODE_OUT,   // Shed mode latched at entry
  output reg         SHED_RECALL_OUT, // Shed recall latched at entry
  output reg         OVERRIDE_ACTIVE, // Host setpoint in use
  output reg  [31:0] ACTIVE_SETPOINT  // Setpoint the loop uses
);

  // Signed float compare, a below b; zero of either sign counts equal
  function flt;
    input [31:0] a;
    input [31:0] b;
    begin
      if (a[31] != b[31])
        flt = a[31] & ~((a[30:0] == 31'h0) & (b[30:0] == 31'h0));
      else if (!a[31])
        flt = a[30:0] < b[30:0];
      else
        flt = a[30:0] > b[30:0];
    end
  endfunction

  // Function codes allowed per port
  function func_ok;
    input       ir;
    input [7:0] f;
    begin
      if (ir)
        func_ok = (f == `FC_READ_CFG) | (f == `FC_WRITE_CFG);
      else
        func_ok = (f == `FC_COILS) | (f == `FC_INPUTS) | (f == `FC_HOLDING) |
                  (f == `FC_INPUT_REGS) | (f == `FC_WRITE_ONE) | (f == `FC_WRITE_MANY) |
                  (f == `FC_REPORT_ID) | (f == `FC_READ_CFG) | (f == `FC_WRITE_CFG);
    end
  endfunction

  reg  [1:0]  st_q;
  reg  [31:0] limit_lo_q;
  reg  [31:0] limit_hi_q;
  reg  [31:0] sp_one_q;
  reg  [31:0] sp_two_q;
  reg  [31:0] host_sp_q;
  reg         sp_count_q;
  reg         override_q;
  reg  [1:0]  mode_q;
  reg  [1:0]  mode_d;
  reg  [16:0] ms_cnt_q;
  reg  [9:0]  ms_in_s_q;
  reg  [7:0]  sec_q;
  reg  [2:0]  key_sync_q;
  reg  [1:0]  sel_sync_q;
  reg  [31:0] rd_data;
  reg         mapped;
  reg         read_only;
  reg  [31:0] clamped;
  wire        is_wr;
  wire        bad_count;
  wire        req_err;
  wire        taken;
  wire        accepted;
  wire        wr_event;
  wire        key_press;
  wire        expired;
  wire        analog_nv;
  wire        digital_nv;
  wire [7:0]  rev_safe;

  assign is_wr     = (REQ_FUNC == `FC_WRITE_ONE) | (REQ_FUNC == `FC_WRITE_MANY) |
                     (REQ_FUNC == `FC_WRITE_CFG);
  assign bad_count = (REQ_TAG == `TAG_SP_COUNT) & (REQ_WDATA[15:1] != 15'h0);
  assign req_err   = ~func_ok(REQ_IR, REQ_FUNC) | ~mapped |
                     (is_wr & read_only) | (is_wr & bad_count);
  // Take only while ready stands, so the first cycle after reset takes no request and gives no answer
  assign taken     = REQ_VALID & REQ_READY & (st_q == `ST_IDLE);
  assign accepted  = taken & ~req_err;
  assign wr_event  = accepted & is_wr;
  assign analog_nv = (REQ_TAG >= `ANALOG_NV_FIRST) & (REQ_TAG <= `ANALOG_NV_LAST);
  assign digital_nv = (REQ_TAG >= `DIGITAL_NV_FIRST) & (REQ_TAG <= `DIGITAL_NV_LAST);
  assign rev_safe  = (SW_REV > `SW_REV_MAX) ? `SW_REV_MAX : SW_REV;

  // Read mux and tag classes; integers zero-extend into the word
  always @* begin
    rd_data   = 32'h0;
    mapped    = 1'b1;
    read_only = 1'b1;
    case (REQ_TAG)
      `TAG_SP_LIMIT_LO:  begin rd_data = limit_lo_q; read_only = 1'b0; end
      `TAG_SP_LIMIT_HI:  begin rd_data = limit_hi_q; read_only = 1'b0; end
      `TAG_LOCAL_SP_ONE: begin rd_data = sp_one_q; read_only = 1'b0; end
      `TAG_LOCAL_SP_TWO: begin rd_data = sp_two_q; read_only = 1'b0; end
      `TAG_HOST_SP:      begin rd_data = host_sp_q; read_only = 1'b0; end
      `TAG_SP_COUNT:     begin rd_data = {31'h0, sp_count_q}; read_only = 1'b0; end
      `TAG_PV_SP_OUT:    rd_data = PROCESS_VALUE;
      `TAG_INPUT_ONE:    rd_data = INPUT_ONE;
      `TAG_INPUT_TWO:    rd_data = INPUT_TWO;
      `TAG_SW_KIND:      rd_data = {16'h0, SW_KIND};
      `TAG_SW_REV:       rd_data = {24'h0, rev_safe};
      `TAG_OPTIONS:      rd_data = {24'h0, OPTION_FLAGS};
      `TAG_PROG_SEG:     rd_data = {16'h0, PROG_SEGMENT};
      `TAG_PROG_MIN:     rd_data = {16'h0, PROG_MINUTES};
      `TAG_PROG_HRS:     rd_data = {16'h0, PROG_HOURS};
      `TAG_CYC_LEFT:     rd_data = {16'h0, PROG_CYC_LEFT};
      `TAG_CYC_INDEX:    rd_data = {16'h0, PROG_CYC_INDEX};
      default: begin
        mapped    = 1'b0;
        read_only = 1'b0;
      end
    endcase
  end

  // Clamp a setpoint write into the limits rather than refusing it
  always @* begin
    if (flt(REQ_WDATA, limit_lo_q))
      clamped = limit_lo_q;
    else if (flt(limit_hi_q, REQ_WDATA))
      clamped = limit_hi_q;
    else
      clamped = REQ_WDATA;
  end

  // Request handler; one request at a time, held off while memory is busy
  always @(posedge CLOCK) begin
    if (RST) begin
      st_q       <= `ST_IDLE;
      REQ_READY  <= 1'b0;
      RSP_VALID  <= 1'b0;
      RSP_ERROR  <= 1'b0;
      RSP_DATA   <= 32'h0;
      NV_REQ     <= 1'b0;
      NV_TAG     <= 8'h0;
      NV_DATA    <= 32'h0;
      limit_lo_q <= `RST_LIMIT_LO;
      limit_hi_q <= `RST_LIMIT_HI;
      sp_one_q   <= `RST_SP;
      sp_two_q   <= `RST_SP;
      host_sp_q  <= `RST_SP;
      sp_count_q <= 1'b0;
    end else begin
      RSP_VALID <= 1'b0;
      NV_REQ    <= 1'b0;
      case (st_q)
        `ST_IDLE: begin
          REQ_READY <= 1'b1;
          if (taken) begin
            RSP_DATA  <= wr_event ? REQ_WDATA : rd_data;
            RSP_ERROR <= req_err;
            NV_TAG    <= REQ_TAG;
            if (!wr_event) begin
              RSP_VALID <= 1'b1;
            end else begin
              case (REQ_TAG)
                `TAG_SP_LIMIT_LO:  limit_lo_q <= REQ_WDATA;
                `TAG_SP_LIMIT_HI:  limit_hi_q <= REQ_WDATA;
                `TAG_LOCAL_SP_ONE: sp_one_q <= clamped;
                `TAG_LOCAL_SP_TWO: sp_two_q <= clamped;
                `TAG_HOST_SP:      host_sp_q <= REQ_WDATA;
                `TAG_SP_COUNT:     sp_count_q <= REQ_WDATA[0];
                default:           host_sp_q <= host_sp_q;
              endcase
              if ((REQ_TAG == `TAG_LOCAL_SP_ONE) || (REQ_TAG == `TAG_LOCAL_SP_TWO))
                NV_DATA <= clamped;
              else
                NV_DATA <= REQ_WDATA;
              if (analog_nv) begin
                NV_REQ    <= 1'b1;
                REQ_READY <= 1'b0;
                st_q      <= `ST_NV_RESP;
              end else if (digital_nv) begin
                NV_REQ    <= 1'b1;
                RSP_VALID <= 1'b1;
                REQ_READY <= 1'b0;
                st_q      <= `ST_NV_BUSY;
              end else begin
                RSP_VALID <= 1'b1;
              end
            end
          end
        end
        `ST_NV_RESP: begin
          // Answer only once the memory cycle is over
          if (NV_DONE) begin
            RSP_VALID <= 1'b1;
            REQ_READY <= 1'b1;
            st_q      <= `ST_IDLE;
          end
        end
        `ST_NV_BUSY: begin
          if (NV_DONE) begin
            REQ_READY <= 1'b1;
            st_q      <= `ST_IDLE;
          end
        end
        default: begin
          REQ_READY <= 1'b0;
          st_q      <= `ST_IDLE;
        end
      endcase
    end
  end

  // Key and select pins come from outside the clock domain
  always @(posedge CLOCK) begin
    if (RST) begin
      key_sync_q <= 3'h0;
      sel_sync_q <= 2'h0;
    end else begin
      key_sync_q <= {key_sync_q[1:0], MANUAL_AUTO_KEY};
      sel_sync_q <= {sel_sync_q[0], SP_TWO_SELECT};
    end
  end
  assign key_press = key_sync_q[1] & ~key_sync_q[2];

  // Shed timer: ms tick divider, then seconds since last accepted traffic
  always @(posedge CLOCK) begin
    if (RST || accepted || (mode_q != `MODE_SLAVE)) begin
      ms_cnt_q  <= 17'h0;
      ms_in_s_q <= 10'h0;
      sec_q     <= 8'h0;
    end else if (ms_cnt_q == MS_CYCLES[16:0] - 17'h1) begin
      ms_cnt_q <= 17'h0;
      if (ms_in_s_q == `MS_PER_SECOND - 10'h1) begin
        ms_in_s_q <= 10'h0;
        if (!expired)
          sec_q <= sec_q + 8'h1;
      end else begin
        ms_in_s_q <= ms_in_s_q + 10'h1;
      end
    end else begin
      ms_cnt_q <= ms_cnt_q + 17'h1;
    end
  end
  // A zero shed time keeps the override alive indefinitely
  assign expired = (SHED_SECONDS != 8'h0) & (sec_q >= SHED_SECONDS);

  // Next communication mode
  always @* begin
    mode_d = mode_q;
    if (!SHED_ENABLE)
      mode_d = `MODE_MONITOR;
    else begin
      case (mode_q)
        `MODE_MONITOR:   if (wr_event) mode_d = `MODE_SLAVE;
        `MODE_SLAVE: begin
          if (key_press)
            mode_d = `MODE_EMERGENCY;
          else if (expired)
            mode_d = `MODE_SHED;
        end
        `MODE_EMERGENCY: if (key_press) mode_d = `MODE_SLAVE;
        `MODE_SHED:      if (wr_event) mode_d = `MODE_SLAVE;
        default:         mode_d = `MODE_MONITOR;
      endcase
    end
  end

  // Mode outputs; override set by a host write beats a clear in that cycle
  always @(posedge CLOCK) begin
    if (RST) begin
      mode_q          <= `MODE_MONITOR;
      COMM_MODE       <= `MODE_MONITOR;
      KEYPAD_LOCK     <= 1'b0;
      SHED_ACTIVE     <= 1'b0;
      SHED_MODE_OUT   <= 2'h0;
      SHED_RECALL_OUT <= 1'b0;
      override_q      <= 1'b0;
      OVERRIDE_ACTIVE <= 1'b0;
      ACTIVE_SETPOINT <= `RST_SP;
    end else begin
      mode_q      <= mode_d;
      COMM_MODE   <= mode_d;
      KEYPAD_LOCK <= (mode_d == `MODE_SLAVE);
      SHED_ACTIVE <= (mode_d == `MODE_SHED);
      if ((mode_d == `MODE_SHED) && (mode_q != `MODE_SHED)) begin
        SHED_MODE_OUT   <= SHED_MODE_CFG;
        SHED_RECALL_OUT <= SHED_RECALL_CFG;
      end
      if (wr_event && (REQ_TAG == `TAG_HOST_SP))
        override_q <= 1'b1;
      else if ((mode_d == `MODE_MONITOR) || (mode_d == `MODE_SHED))
        override_q <= 1'b0;
      OVERRIDE_ACTIVE <= override_q & (mode_q == `MODE_SLAVE);
      if (override_q && (mode_q == `MODE_SLAVE))
        ACTIVE_SETPOINT <= host_sp_q;
      else if (sp_count_q && sel_sync_q[1])
        ACTIVE_SETPOINT <= sp_two_q;
      else
        ACTIVE_SETPOINT <= sp_one_q;
    end
  end

endmodule // param_regs

//--- shared/param_regs_defines.vh
`ifndef PARAM_REGS_DEFINES_VH
`define PARAM_REGS_DEFINES_VH

// Register tags
`define TAG_SP_LIMIT_LO   8'h07
`define TAG_SP_LIMIT_HI   8'h08
`define TAG_LOCAL_SP_ONE  8'h27
`define TAG_LOCAL_SP_TWO  8'h35
`define TAG_PV_SP_OUT     8'h7a
`define TAG_INPUT_ONE     8'h7b
`define TAG_INPUT_TWO     8'h7c
`define TAG_HOST_SP       8'h7d
`define TAG_SW_KIND       8'h9d
`define TAG_SW_REV        8'ha7
`define TAG_SP_COUNT      8'had
`define TAG_OPTIONS       8'hb9
`define TAG_PROG_SEG      8'hfb
`define TAG_PROG_MIN      8'hfc
`define TAG_PROG_HRS      8'hfd
`define TAG_CYC_LEFT      8'hfe
`define TAG_CYC_INDEX     8'hff

// Non-volatile ranges
`define ANALOG_NV_FIRST   8'h01
`define ANALOG_NV_LAST    8'h74
`define DIGITAL_NV_FIRST  8'h80
`define DIGITAL_NV_LAST   8'hfa

// Function codes
`define FC_COILS          8'h01
`define FC_INPUTS         8'h02
`define FC_HOLDING        8'h03
`define FC_INPUT_REGS     8'h04
`define FC_WRITE_ONE      8'h06
`define FC_WRITE_MANY     8'h10
`define FC_REPORT_ID      8'h11
`define FC_READ_CFG       8'h14
`define FC_WRITE_CFG      8'h15

// Reset values and revision limit
`define RST_LIMIT_LO      32'h00000000
`define RST_LIMIT_HI      32'h447a0000
`define RST_SP            32'h00000000
`define SW_REV_MAX        8'hfe

// Communication modes
`define MODE_MONITOR      2'h0
`define MODE_SLAVE        2'h1
`define MODE_EMERGENCY    2'h2
`define MODE_SHED         2'h3

// Request handler states
`define ST_IDLE           2'h0
`define ST_NV_RESP        2'h1
`define ST_NV_BUSY        2'h2

// Timing
`define CLK_PERIOD_NS     8
`define TICK_TIME_MS      1
`define NS_PER_MS         1000000
`define MS_PER_SECOND     10'h3e8

`endif

//--- verif/nv_store_model.sv
`timescale 1ns/1ns
module nv_store_model (
  input  wire logic       clk,  // Clock
  input  wire logic       rst,  // Synchronous reset
  input  wire logic       req,  // Commit start pulse
  input  wire logic [7:0] lag,  // Cycles a commit takes, 1 or more
  output logic            done  // Commit finished pulse
);
  logic [7:0] left_q;

  // One commit at a time; a slow lag makes the host wait for the write cycle
  always @(posedge clk) begin
    done <= 1'b0;
    if (rst) begin
      left_q <= 8'h00;
    end else if (req) begin
      left_q <= lag;
    end else if (left_q != 8'h00) begin
      left_q <= left_q - 8'h01;
      done   <= (left_q == 8'h01);
    end
  end
endmodule // nv_store_model

//--- verif/param_regs_checker.sv
`timescale 1ns/1ns
module param_regs_checker (
  input wire logic        CLOCK,       // Clock
  input wire logic        RST,         // Reset
  input wire logic        REQ_VALID,   // Request present
  input wire logic        REQ_READY,   // Request taken
  input wire logic        REQ_IR,      // Infrared source
  input wire logic [7:0]  REQ_FUNC,    // Function code
  input wire logic [7:0]  REQ_TAG,     // Register tag
  input wire logic [31:0] REQ_WDATA,   // Write data
  input wire logic        RSP_VALID,   // Answer
  input wire logic        RSP_ERROR,   // Exception
  input wire logic        NV_REQ,      // Commit start
  input wire logic        SHED_ENABLE, // Shed timer on
  input wire logic [1:0]  COMM_MODE,   // Mode
  input wire logic        KEYPAD_LOCK, // Keypad locked
  input wire logic        SHED_ACTIVE  // Shed state
);
  logic take;
  logic wr;
  logic ctl;

  // Taken requests, refused ones included, wired single writes, control data tags
  assign take = REQ_VALID && REQ_READY;
  assign wr   = take && !REQ_IR && REQ_FUNC == 8'h06;
  assign ctl  = REQ_TAG >= 8'h7a && REQ_TAG <= 8'h7c;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  ro_write_err_a: assert property (wr && ctl |=> RSP_VALID && RSP_ERROR)
    else $error("control data write not refused");
  analog_nv_a: assert property (wr && REQ_TAG == 8'h27 |=> NV_REQ && !RSP_VALID)
    else $error("analog write answered before commit");
  digital_nv_a: assert property (wr && REQ_TAG == 8'had && REQ_WDATA[15:0] < 16'h2
    |=> NV_REQ && RSP_VALID && !RSP_ERROR) else $error("digital write not committed");
  count_range_a: assert property (wr && REQ_TAG == 8'had && REQ_WDATA[15:0] > 16'h1
    |=> RSP_ERROR && !NV_REQ) else $error("bad setpoint count accepted");
  ir_code_a: assert property (take && REQ_IR && REQ_FUNC < 8'h14 |=> RSP_ERROR)
    else $error("infrared code not refused");
  slave_entry_a: assert property (wr && SHED_ENABLE && REQ_TAG == 8'h7d && COMM_MODE != 2'h2
    |-> ##[1:3] (COMM_MODE == 2'h1 && KEYPAD_LOCK)) else $error("no slave entry");
  shed_entry_a: assert property ($rose(SHED_ACTIVE) |-> $past(COMM_MODE) == 2'h1
    && COMM_MODE == 2'h3) else $error("shed entered from wrong mode");
  monitor_mode_a: assert property (!SHED_ENABLE |=> COMM_MODE == 2'h0 && !KEYPAD_LOCK)
    else $error("not in monitor mode");
endmodule // param_regs_checker

bind param_regs param_regs_checker chk (.CLOCK(CLOCK), .RST(RST), .REQ_VALID(REQ_VALID),
  .REQ_READY(REQ_READY), .REQ_IR(REQ_IR), .REQ_FUNC(REQ_FUNC), .REQ_TAG(REQ_TAG),
  .REQ_WDATA(REQ_WDATA), .RSP_VALID(RSP_VALID), .RSP_ERROR(RSP_ERROR), .NV_REQ(NV_REQ),
  .SHED_ENABLE(SHED_ENABLE), .COMM_MODE(COMM_MODE), .KEYPAD_LOCK(KEYPAD_LOCK),
  .SHED_ACTIVE(SHED_ACTIVE));

//--- verif/param_regs_tb.sv
`timescale 1ns/1ns
`include "param_regs_defines.vh"
module param_regs_tb;
  logic        clock = 1'b0, rst = 1'b1, rv = 1'b0, ir = 1'b0, shed_en = 1'b0;
  logic        recall = 1'b0, key = 1'b0, sel_two = 1'b0, nv_seen = 1'b0;
  logic        ready, rsp_v, rsp_e, nv_req, nv_done, lock, shed_act, recall_out, ovr, e;
  logic [1:0]  smode = 2'h0, mode, smode_out;
  logic [7:0]  func = 8'h00, tag = 8'h00, opts = 8'h00, lag = 8'h01, nv_tag, t;
  logic [15:0] seg = 16'h1, mins = 16'h0, hrs = 16'h0, cyl = 16'h0, cyi = 16'h0;
  logic [31:0] wd = 32'h0, pv = 32'h0, in1 = 32'h0, in2 = 32'h0, rd, act_sp, d, v, sp1, sp2;
  logic [31:0] nv_data;
  logic [7:0]  tags [16];
  logic [31:0] exps [16];
  int          failures = 0, comparisons = 0, n, m, nv_cnt = 0;

  // 125 MHz clock
  always #4 clock = ~clock;

  param_regs #(.MS_CYCLES(4)) uut (
    .CLOCK(clock), .RST(rst), .REQ_VALID(rv), .REQ_IR(ir), .REQ_FUNC(func), .REQ_TAG(tag),
    .REQ_WDATA(wd), .REQ_READY(ready), .RSP_VALID(rsp_v), .RSP_ERROR(rsp_e), .RSP_DATA(rd),
    .NV_REQ(nv_req), .NV_TAG(nv_tag), .NV_DATA(nv_data), .NV_DONE(nv_done), .PROCESS_VALUE(pv),
    .INPUT_ONE(in1), .INPUT_TWO(in2), .OPTION_FLAGS(opts), .PROG_SEGMENT(seg),
    .PROG_MINUTES(mins), .PROG_HOURS(hrs), .PROG_CYC_LEFT(cyl), .PROG_CYC_INDEX(cyi),
    .SHED_ENABLE(shed_en), .SHED_SECONDS(8'h01), .SHED_MODE_CFG(smode),
    .SHED_RECALL_CFG(recall), .MANUAL_AUTO_KEY(key), .SP_TWO_SELECT(sel_two),
    .COMM_MODE(mode), .KEYPAD_LOCK(lock), .SHED_ACTIVE(shed_act), .SHED_MODE_OUT(smode_out),
    .SHED_RECALL_OUT(recall_out), .OVERRIDE_ACTIVE(ovr), .ACTIVE_SETPOINT(act_sp));

  nv_store_model nvm (.clk(clock), .rst(rst), .req(nv_req), .lag(lag), .done(nv_done));

  // Commit activity as the host sees it; cleared when a request is taken
  always @(posedge clock) begin
    nv_cnt <= nv_cnt + nv_req;
    if (rv === 1'b1 && ready === 1'b1) nv_seen <= 1'b0;
    else if (nv_done === 1'b1) nv_seen <= 1'b1;
  end

  task chk(input logic [39:0] got, input logic [39:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One host transaction: held until taken, then wait for the answer
  task xfer(input logic i, input logic [7:0] f, input logic [7:0] g, input logic [31:0] w);
    @(negedge clock);
    {ir, func, tag, wd, rv} = {i, f, g, w, 1'b1};
    n = 0;
    do begin @(posedge clock); n++; end while (ready !== 1'b1 && n < 500);
    @(negedge clock);
    rv = 1'b0;
    while (rsp_v !== 1'b1 && n < 500) begin @(posedge clock); n++; end
    e = rsp_e;
    d = rd;
    if (n >= 500) begin failures++; $display("Error at %0t: no answer", $time); end
    // Quiet gap, scaled far down so the run stays short
    @(posedge clock);
  endtask

  // Wired ports read with 01..04, 11, 14; infrared reads only with 14; all writes hit RO
  function logic exp_err(input logic i, input logic [7:0] f);
    return i ? f != 8'h14 : !(f inside {8'h01, 8'h02, 8'h03, 8'h04, 8'h11, 8'h14});
  endfunction

  function logic [31:0] clamp(input logic [31:0] x);
    return x[31] ? `RST_LIMIT_LO : (x > `RST_LIMIT_HI ? `RST_LIMIT_HI : x);
  endfunction

  task conclude;
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Watchdog far beyond the few thousand cycles the run needs
  initial begin
    #200000;
    failures++;
    $display("Error at %0t: watchdog expired", $time);
    conclude;
  end

  initial begin
    m = $urandom(32'h2cb0c7d7);
    {pv, in1, in2, opts} = {$urandom, $urandom, $urandom, 8'($urandom)};
    {seg, mins, hrs} = {16'(1 + $urandom % 12), 16'($urandom % 60), 16'($urandom % 100)};
    {cyl, cyi, smode, recall} = {16'($urandom % 101), 16'($urandom % 101), 3'($urandom)};
    tags = '{8'h07, 8'h08, 8'h27, 8'h35, 8'had, 8'h7a, 8'h7b, 8'h7c, 8'h9d, 8'ha7, 8'hb9,
             8'hfb, 8'hfc, 8'hfd, 8'hfe, 8'hff};
    exps = '{`RST_LIMIT_LO, `RST_LIMIT_HI, 32'h0, 32'h0, 32'h0, pv, in1, in2, 32'h1, 32'h1,
             {24'h0, opts}, {16'h0, seg}, {16'h0, mins}, {16'h0, hrs}, {16'h0, cyl},
             {16'h0, cyi}};
    repeat (10) @(posedge clock);
    @(negedge clock);
    rst = 1'b0;
    // Reset values and read-only data, then writes to read-only places
    for (int k = 0; k < 16; k++) begin
      xfer(1'b0, `FC_HOLDING, tags[k], 32'h0);
      chk({e, d}, {1'b0, exps[k]});
      if (k > 4) begin
        xfer(1'b0, `FC_WRITE_ONE, tags[k], $urandom);
        chk({e, d}, {1'b1, exps[k]});
      end
    end
    // Every function code from 0 to 23 on both kinds of port
    for (int f = 0; f < 48; f++) begin
      xfer(f[0], f[8:1], `TAG_SW_KIND, 32'h5);
      chk(e, exp_err(f[0], f[8:1]));
    end
    // Setpoints: prompt and slow commits, in range and past either limit
    for (int k = 0; k < 6; k++) begin
      lag = k[1] ? 8'h28 : 8'h01;
      t = k[0] ? `TAG_LOCAL_SP_TWO : `TAG_LOCAL_SP_ONE;
      v = $urandom % `RST_LIMIT_HI;
      if (k % 3 > 0) v = {k % 3 == 2, 31'h45000000} | $urandom % 32'h100000;
      xfer(1'b0, `FC_WRITE_ONE, t, v);
      chk({e, nv_seen}, 2'b01);
      chk(nv_data, clamp(v));
      xfer(1'b0, `FC_HOLDING, t, 32'h0);
      chk(d, clamp(v));
      if (k[0]) sp2 = clamp(v);
      else sp1 = clamp(v);
    end
    chk(mode, `MODE_MONITOR);
    // Second setpoint enabled, an out-of-range count refused, then back to one
    xfer(1'b0, `FC_WRITE_ONE, `TAG_SP_COUNT, 32'h1);
    chk({e, nv_seen, nv_tag}, {2'b00, `TAG_SP_COUNT});
    xfer(1'b0, `FC_WRITE_ONE, `TAG_SP_COUNT, 32'h2);
    chk(e, 1'b1);
    @(negedge clock);
    sel_two = 1'b1;
    repeat (4) @(posedge clock);
    xfer(1'b0, `FC_HOLDING, `TAG_SP_COUNT, 32'h0);
    chk(d, 32'h1);
    chk(act_sp, sp2);
    xfer(1'b0, `FC_WRITE_ONE, `TAG_SP_COUNT, 32'h0);
    // The active setpoint follows the count one cycle after the write lands
    @(negedge clock);
    chk(act_sp, sp1);
    // Override with the shed timer on, key presses, then silence until shed
    @(negedge clock);
    shed_en = 1'b1;
    m = nv_cnt;
    v = $urandom % `RST_LIMIT_HI;
    xfer(1'b0, `FC_WRITE_ONE, `TAG_HOST_SP, v);
    repeat (2) @(posedge clock);
    chk({mode, lock, ovr, act_sp}, {`MODE_SLAVE, 2'b11, v});
    chk(nv_cnt - m, 40'h0);
    for (int k = 0; k < 2; k++) begin
      @(negedge clock);
      key = 1'b1;
      repeat (6) @(posedge clock);
      chk({mode, ovr}, k ? {`MODE_SLAVE, 1'b1} : {`MODE_EMERGENCY, 1'b0});
      @(negedge clock);
      key = 1'b0;
      repeat (6) @(posedge clock);
    end
    n = 0;
    while (shed_act !== 1'b1 && n < 9000) begin @(posedge clock); n++; end
    // Override indication drops one cycle after the shed entry
    @(negedge clock);
    chk({mode, smode_out, recall_out, ovr, n > 3500}, {`MODE_SHED, smode, recall, 2'b01});
    @(negedge clock);
    shed_en = 1'b0;
    repeat (2) @(posedge clock);
    chk({mode, lock}, {`MODE_MONITOR, 1'b0});
    conclude;
  end
endmodule // param_regs_tb
